// File: core/tof_pkg.sv
// Constants for the thermal and overcurrent sticky flag bank
package tof_pkg;
  localparam int TOF_ADDR_W = 8;
  localparam int TOF_DATA_W = 8;
  localparam logic [7:0] TOF_OFS_THERMAL_HOT_FLAGS = 8'hb5;
  localparam logic [7:0] TOF_OFS_OVERCURRENT_FLAGS = 8'hb6;
  localparam int TOF_NUM_SENSORS = 5;
  localparam int TOF_NUM_CONTROLLERS = 3;
  localparam logic [7:0] TOF_RESET_VALUE = 8'h00;
  localparam logic [7:0] TOF_READ_ZERO = 8'h00;
  // Thermal field positions
  localparam int TOF_BIT_BOTTOM_RIGHT_HOT = 0;
  localparam int TOF_BIT_TOP_LEFT_HOT = 1;
  localparam int TOF_BIT_TOP_RIGHT_HOT = 2;
  localparam int TOF_BIT_TERMINATION_REGULATOR_OVER_THRESHOLD = 3;
  localparam int TOF_BIT_REST_OF_DIE_HOT = 4;
  // Overcurrent field positions
  localparam int TOF_BIT_FIRST_CONTROLLER_OVERCURRENT = 0;
  localparam int TOF_BIT_SECOND_CONTROLLER_OVERCURRENT = 1;
  localparam int TOF_BIT_THIRD_CONTROLLER_OVERCURRENT = 2;
endpackage : tof_pkg

// File: core/tof_sticky_flag.sv
// One sticky flag bit with synchronised detector and write-one-to-clear
`timescale 1ns/1ps
module tof_sticky_flag (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic detect_async,
  input wire logic clear_req,
  output logic flag
);
  import tof_pkg::*;

  logic sync1_r;
  logic sync2_r;
  logic flag_r;
  logic flag_nxt;

  // Set beats clear so an event in the clear cycle is kept
  always_comb begin
    flag_nxt = flag_r;
    if (clear_req) begin
      flag_nxt = 1'b0;
    end
    if (sync2_r) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      sync1_r <= detect_async;
      sync2_r <= sync1_r;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;
endmodule : tof_sticky_flag

// File: core/tof_status_flags.sv
// Thermal hot and overcurrent sticky status register bank
// Functional notes
// - Five separate temperature sensor inputs each drive their own hot flag bit.
// - Bit 4 of the thermal flags latches when the rest-of-die sensor is above hot threshold.
// - Bit 3 of the thermal flags latches when the termination regulator sensor is hot.
// - Bit 2 of the thermal flags latches when the top-right corner sensor is hot.
// - Bit 1 of the thermal flags latches when the top-left corner sensor is hot.
// - Bit 0 of the thermal flags latches when the bottom-right corner sensor is hot.
// - Writing one to a set flag clears it unless its synchronised detector is still high, and the host acknowledges flags that way.
// - The thermal flags sit at offset b5 and reset to zero.
// - The overcurrent flags sit at offset b6 and reset to zero.
// - Bit 2 of the overcurrent flags latches on a third controller low-side overcurrent.
// - Bit 1 of the overcurrent flags latches on a second controller low-side overcurrent.
// - Bit 0 of the overcurrent flags latches on a first controller low-side overcurrent.
`timescale 1ns/1ps
module tof_status_flags (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rest_of_die_hot,
  input wire logic termination_regulator_over_threshold,
  input wire logic top_right_hot,
  input wire logic top_left_hot,
  input wire logic bottom_right_hot,
  input wire logic first_controller_overcurrent,
  input wire logic second_controller_overcurrent,
  input wire logic third_controller_overcurrent,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [tof_pkg::TOF_ADDR_W-1:0] reg_addr,
  input wire logic [tof_pkg::TOF_DATA_W-1:0] reg_wdata,
  output logic [tof_pkg::TOF_DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic [tof_pkg::TOF_DATA_W-1:0] thermal_hot_flags,
  output logic [tof_pkg::TOF_DATA_W-1:0] overcurrent_flags
);
  import tof_pkg::*;

  localparam int NFLAGS = TOF_NUM_SENSORS + TOF_NUM_CONTROLLERS;

  logic [NFLAGS-1:0] detect;
  logic [NFLAGS-1:0] clear;
  logic [NFLAGS-1:0] flag;
  logic [TOF_DATA_W-1:0] therm_view;
  logic [TOF_DATA_W-1:0] oc_view;
  logic wr_therm;
  logic wr_oc;
  logic [TOF_DATA_W-1:0] rdata_r;
  logic [TOF_DATA_W-1:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [TOF_DATA_W-1:0] therm_out_r;
  logic [TOF_DATA_W-1:0] oc_out_r;

  // Detector mapping onto flag slots
  always_comb begin
    detect = '0;
    detect[TOF_BIT_BOTTOM_RIGHT_HOT] = bottom_right_hot;
    detect[TOF_BIT_TOP_LEFT_HOT] = top_left_hot;
    detect[TOF_BIT_TOP_RIGHT_HOT] = top_right_hot;
    detect[TOF_BIT_TERMINATION_REGULATOR_OVER_THRESHOLD] =
      termination_regulator_over_threshold;
    detect[TOF_BIT_REST_OF_DIE_HOT] = rest_of_die_hot;
    detect[TOF_NUM_SENSORS + TOF_BIT_FIRST_CONTROLLER_OVERCURRENT] =
      first_controller_overcurrent;
    detect[TOF_NUM_SENSORS + TOF_BIT_SECOND_CONTROLLER_OVERCURRENT] =
      second_controller_overcurrent;
    detect[TOF_NUM_SENSORS + TOF_BIT_THIRD_CONTROLLER_OVERCURRENT] =
      third_controller_overcurrent;
  end

  assign wr_therm = reg_wr_en && (reg_addr == TOF_OFS_THERMAL_HOT_FLAGS);
  assign wr_oc = reg_wr_en && (reg_addr == TOF_OFS_OVERCURRENT_FLAGS);

  // Only implemented bits see the write; reserved bits are dropped
  always_comb begin
    clear = '0;
    if (wr_therm) begin
      clear[TOF_NUM_SENSORS-1:0] = reg_wdata[TOF_NUM_SENSORS-1:0];
    end
    if (wr_oc) begin
      clear[NFLAGS-1:TOF_NUM_SENSORS] = reg_wdata[TOF_NUM_CONTROLLERS-1:0];
    end
  end

  // Each flag has its own synchroniser and latch
  genvar gi;
  generate
    for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
      tof_sticky_flag u_flag (
        .core_clk(core_clk),
        .srst(srst),
        .detect_async(detect[gi]),
        .clear_req(clear[gi]),
        .flag(flag[gi])
      );
    end
  endgenerate

  always_comb begin
    therm_view = TOF_READ_ZERO;
    oc_view = TOF_READ_ZERO;
    therm_view[TOF_NUM_SENSORS-1:0] = flag[TOF_NUM_SENSORS-1:0];
    oc_view[TOF_NUM_CONTROLLERS-1:0] = flag[NFLAGS-1:TOF_NUM_SENSORS];
  end

  // Read data registered one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd_en;
    if (reg_rd_en) begin
      case (reg_addr)
        TOF_OFS_THERMAL_HOT_FLAGS: rdata_nxt = therm_view;
        TOF_OFS_OVERCURRENT_FLAGS: rdata_nxt = oc_view;
        default: rdata_nxt = TOF_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_r <= TOF_RESET_VALUE;
      rvalid_r <= 1'b0;
      therm_out_r <= TOF_RESET_VALUE;
      oc_out_r <= TOF_RESET_VALUE;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      therm_out_r <= therm_view;
      oc_out_r <= oc_view;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign thermal_hot_flags = therm_out_r;
  assign overcurrent_flags = oc_out_r;
endmodule : tof_status_flags

// File: test/tof_status_flags_assertions.sv
// Port checker for the flag bank
`timescale 1ns/1ps
module tof_status_flags_assertions
  import tof_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rest_of_die_hot,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [7:0] thermal_hot_flags,
  input wire logic [7:0] overcurrent_flags
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic clr4;
  assign clr4 = reg_wr_en && reg_addr == TOF_OFS_THERMAL_HOT_FLAGS && reg_wdata[4];
  chk_rvalid_lag: assert property (reg_rvalid == $past(reg_rd_en))
    else $error("rvalid lag");
  chk_rsvd_zero: assert property ((thermal_hot_flags[7:5] | overcurrent_flags[7:3]) == 0)
    else $error("reserved set");
  chk_reset_clear: assert property ($past(srst) |->
    (thermal_hot_flags | overcurrent_flags) == 0) else $error("not reset");
  chk_rd_thermal: assert property (reg_rd_en && reg_addr == 8'hb5 |=>
    reg_rdata == thermal_hot_flags) else $error("thermal read");
  chk_rd_oc: assert property (reg_rd_en && reg_addr == 8'hb6 |=>
    reg_rdata == overcurrent_flags) else $error("oc read");
  chk_die_set: assert property (rest_of_die_hot [*6] |=> thermal_hot_flags[4])
    else $error("no set");
  chk_die_hold: assert property (thermal_hot_flags[4] && !$past(clr4) |=> thermal_hot_flags[4])
    else $error("dropped");
  chk_die_clear: assert property (!rest_of_die_hot [*6] ##0 clr4 |=> ##1 !thermal_hot_flags[4])
    else $error("no clear");
endmodule : tof_status_flags_assertions
bind tof_status_flags tof_status_flags_assertions chk (.core_clk, .srst, .rest_of_die_hot,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .thermal_hot_flags,
  .overcurrent_flags);

// File: test/tof_host_model.sv
// Host model driving the register strobes
`timescale 1ns/1ps
module tof_host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr_en = 1'b0,
  output logic reg_rd_en = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  task automatic acc(input w, input [7:0] a, d, output [7:0] q);
    @(negedge core_clk);
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    // Inverted leftovers so stale lines never pass
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge core_clk);
    q = reg_rdata;
  endtask : acc
endmodule : tof_host_model

// File: test/tof_status_flags_tb.sv
// Self-checking bench for the flag bank
`timescale 1ns/1ps
module tof_status_flags_tb;
  logic core_clk, srst, reg_wr_en, reg_rd_en, reg_rvalid;
  logic [7:0] det, reg_addr, reg_wdata, reg_rdata, thermal_hot_flags, overcurrent_flags, q;
  int n_errors, compares;
  tof_host_model host (.core_clk, .reg_rdata, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata);
  tof_status_flags dut (.core_clk, .srst, .rest_of_die_hot(det[4]),
    .termination_regulator_over_threshold(det[3]), .top_right_hot(det[2]),
    .top_left_hot(det[1]), .bottom_right_hot(det[0]), .first_controller_overcurrent(det[5]),
    .second_controller_overcurrent(det[6]), .third_controller_overcurrent(det[7]), .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .thermal_hot_flags,
    .overcurrent_flags);
  task automatic rd(input [7:0] a, e);
    host.acc(1'b0, a, 8'h00, q);
    compares++;
    if (q !== e) begin
      n_errors++;
      $display("wrong value rdata %h expected %h seen %h", a, e, q);
    end
  endtask : rd
  task automatic chk_out(input [7:0] e, s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value flag mirror expected %h seen %h", e, s);
    end
  endtask : chk_out
  task automatic pulse(input [7:0] m);
    det = m;
    repeat (6) @(negedge core_clk);
    det = 8'h00;
    repeat (6) @(negedge core_clk);
  endtask : pulse
  task automatic t_flags();
    logic [7:0] a, m;
    for (int i = 0; i < 8; i++) begin
      a = (i < 5) ? 8'hb5 : 8'hb6;
      m = 8'h01 << ((i < 5) ? i : i - 5);
      pulse(8'h01 << i);
      rd(a, m);
      chk_out(m, (i < 5) ? thermal_hot_flags : overcurrent_flags);
      host.acc(1'b1, a, 8'h00, q);
      rd(a, m);
      host.acc(1'b1, a, m, q);
      rd(a, 8'h00);
      chk_out(8'h00, (i < 5) ? thermal_hot_flags : overcurrent_flags);
    end
    $display("test flags done");
  endtask : t_flags
  task automatic t_set_wins();
    // Detector still high while the host clears: the flag must survive
    det = 8'h01;
    repeat (6) @(negedge core_clk);
    host.acc(1'b1, 8'hb5, 8'h01, q);
    rd(8'hb5, 8'h01);
    det = 8'h00;
    repeat (4) @(negedge core_clk);
    host.acc(1'b1, 8'hb5, 8'h01, q);
    rd(8'hb5, 8'h00);
    chk_out(8'h00, thermal_hot_flags);
    $display("test set wins done");
  endtask : t_set_wins
  task automatic t_reserved();
    pulse(8'hff);
    rd(8'hb5, 8'h1f);
    rd(8'hb6, 8'h07);
    host.acc(1'b1, 8'hb7, 8'hff, q);
    rd(8'hb7, 8'h00);
    srst = 1'b1;
    @(negedge core_clk);
    srst = 1'b0;
    rd(8'hb5, 8'h00);
    rd(8'hb6, 8'h00);
    chk_out(8'h00, thermal_hot_flags | overcurrent_flags);
    $display("test reserved and reset done");
  endtask : t_reserved
  task automatic give_verdict();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    det = 8'h00;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    t_flags();
    t_set_wins();
    t_reserved();
    give_verdict();
  end
endmodule : tof_status_flags_tb
